// ### common/nvseq_map.svh
// Constants for the save/restore sequence host: command addresses, timing, wait defaults.
// Assumes a 10 MHz controller clock and an asynchronous 8K x 8 memory with shadow store.
// Summary of operation
// (RULE1) The save command is six chip-select reads at 0000, 1555, 0aaa, 1fff, 10f0, 0f0f.
// (RULE2) The restore command is the same five reads followed by a read at 0f0e.
// (RULE3) The six command addresses go out as consecutive accesses in exactly that order.
// (RULE4) Write strobe stays high through all six command accesses.
// (RULE5) No other read or write is slipped into a running command sequence.
// (RULE6) Once a save starts the memory ignores inputs, so the host leaves it alone until done.
// (RULE7) A restore clears then refills the memory, so the host waits it out before accessing.
// (RULE8) Command steps are issued as read cycles, each framed by chip select, never writes.
// (RULE9) After a finished or aborted sequence the controller is idle and starts again at step 0.
`ifndef NVSEQ_MAP_SVH
`define NVSEQ_MAP_SVH

`define SEQ_ADDR_0      13'h0000
`define SEQ_ADDR_1      13'h1555
`define SEQ_ADDR_2      13'h0aaa
`define SEQ_ADDR_3      13'h1fff
`define SEQ_ADDR_4      13'h10f0
`define SEQ_ADDR_SAVE   13'h0f0f
`define SEQ_ADDR_REST   13'h0f0e
`define SEQ_LAST_STEP   3'h5

`define CLK_PERIOD_NS   100
`define T_ACCESS_NS     45
`define ACC_CYC         (4'((`T_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))

`define SAVE_WAIT_DEF   16'h1000
`define REST_WAIT_DEF   16'h1000

`endif

// ### common/nvseq_pkg.sv
// Types shared by the sequence host and its bus cycle generator.
// Assumes nvseq_map.svh for all numeric constants.
package nvseq_pkg;

    typedef enum logic [1:0] {
        OP_READ    = 2'b00,
        OP_WRITE   = 2'b01,
        OP_SAVE    = 2'b10,
        OP_RESTORE = 2'b11
    } op_e;

    typedef enum logic [1:0] {
        M_IDLE   = 2'b00,
        M_ACC    = 2'b01,
        M_SEQ    = 2'b10,
        M_NVWAIT = 2'b11
    } main_st_e;

    typedef enum logic [1:0] {
        G_IDLE   = 2'b00,
        G_SETUP  = 2'b01,
        G_STROBE = 2'b10,
        G_RECOV  = 2'b11
    } gen_st_e;

endpackage

// ### common/cyc_if.sv
// Request and answer for one memory bus cycle between controller and cycle generator.
// Assumes a single clock domain; req is a one-cycle pulse taken only while generator is idle.
`timescale 1ns/10ps
interface cyc_if;
    logic        req;
    logic        we;
    logic [12:0] word_addr;
    logic [7:0]  wdata;
    logic        ack;
    logic [7:0]  rdata;

    modport ctrl (output req, output we, output word_addr, output wdata,
                  input ack, input rdata);
    modport gen  (input req, input we, input word_addr, input wdata,
                  output ack, output rdata);
endinterface

// ### core/cycle_gen.sv
// Generates one chip-select framed read or write on the memory pins per request.
// Assumes requests arrive only while idle; all pin outputs come from flip-flops.
`timescale 1ns/10ps
`include "nvseq_map.svh"
module cycle_gen (
    input  wire logic        ref_clk_i,
    input  wire logic        nrst_i,
    input  wire logic        en_i,
    cyc_if.gen               cyc,
    input  wire logic [7:0]  dq_i,
    output logic      [7:0]  dq_o,
    output logic             dq_oe_n_o,
    output logic      [12:0] word_addr_o,
    output logic             cs_n_o,
    output logic             we_n_o,
    output logic             oe_n_o
);
    typedef struct packed {
        nvseq_pkg::gen_st_e st;
        logic [3:0]         cnt;
        logic               we;
        logic [12:0]        addr;
        logic [7:0]         wdata;
        logic               dq_oe_n;
        logic               cs_n;
        logic               we_n;
        logic               oe_n;
        logic               ack;
        logic [7:0]         rdata;
    } gen_s;

    gen_s q, d;

    // Address settles a full cycle before chip select falls and after it rises
    always_comb begin
        d     = q;
        d.ack = 1'b0;
        unique case (q.st)
            nvseq_pkg::G_IDLE: begin
                if (cyc.req) begin
                    d.addr  = cyc.word_addr;
                    d.we    = cyc.we;
                    d.wdata = cyc.wdata;
                    d.st    = nvseq_pkg::G_SETUP;
                end
            end
            nvseq_pkg::G_SETUP: begin
                d.cs_n    = 1'b0;            // Each step framed by its own select [RULE8]
                d.we_n    = ~q.we;           // Strobe high on every read [RULE4]
                d.oe_n    = q.we;
                d.dq_oe_n = ~q.we;
                d.cnt     = `ACC_CYC;
                d.st      = nvseq_pkg::G_STROBE;
            end
            nvseq_pkg::G_STROBE: begin
                if (q.cnt <= 4'h1) begin
                    d.rdata = dq_i;
                    d.cs_n  = 1'b1;
                    d.we_n  = 1'b1;
                    d.oe_n  = 1'b1;
                    d.ack   = 1'b1;
                    d.st    = nvseq_pkg::G_RECOV;
                end else begin
                    d.cnt = q.cnt - 4'h1;
                end
            end
            nvseq_pkg::G_RECOV: begin
                // Write data held one cycle past the strobe for hold time
                d.dq_oe_n = 1'b1;
                d.st      = nvseq_pkg::G_IDLE;
            end
        endcase
    end

    // Clock enable freezes the whole cycle
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q <= '{st: nvseq_pkg::G_IDLE, cnt: 4'h0, we: 1'b0, addr: 13'h0000,
                   wdata: 8'h00, dq_oe_n: 1'b1, cs_n: 1'b1, we_n: 1'b1,
                   oe_n: 1'b1, ack: 1'b0, rdata: 8'h00};
        end else if (en_i) begin
            q <= d;
        end
    end

    assign cyc.ack     = q.ack;
    assign cyc.rdata   = q.rdata;
    assign dq_o        = q.wdata;
    assign dq_oe_n_o   = q.dq_oe_n;
    assign word_addr_o = q.addr;
    assign cs_n_o      = q.cs_n;
    assign we_n_o      = q.we_n;
    assign oe_n_o      = q.oe_n;
endmodule // cycle_gen

// ### core/nv_host_ctrl.sv
// Host controller for a memory with shadow store: plain reads/writes plus save/restore.
// Assumes pins synchronous to ref_clk_i and that nothing else drives the memory bus.
`timescale 1ns/10ps
`include "nvseq_map.svh"
module nv_host_ctrl #(
    parameter logic [15:0] SAVE_WAIT = `SAVE_WAIT_DEF,
    parameter logic [15:0] REST_WAIT = `REST_WAIT_DEF
) (
    input  wire logic        ref_clk_i,
    input  wire logic        nrst_i,
    input  wire logic        en_i,
    input  wire logic        cmd_valid_i,
    input  wire logic [1:0]  cmd_op_i,
    input  wire logic [12:0] cmd_word_addr_i,
    input  wire logic [7:0]  cmd_wdata_i,
    output logic             cmd_ready_o,
    output logic             rsp_valid_o,
    output logic      [7:0]  rsp_rdata_o,
    output logic             busy_o,
    output logic             done_o,
    input  wire logic [7:0]  dq_i,
    output logic      [7:0]  dq_o,
    output logic             dq_oe_n_o,
    output logic      [12:0] word_addr_o,
    output logic             cs_n_o,
    output logic             we_n_o,
    output logic             oe_n_o
);
    typedef struct packed {
        nvseq_pkg::main_st_e st;
        nvseq_pkg::op_e      op;
        logic [2:0]          step;
        logic [15:0]         wait_cnt;
        logic                req;
        logic                we;
        logic [12:0]         addr;
        logic [7:0]          wdata;
        logic                ready;
        logic                rsp_valid;
        logic [7:0]          rdata;
        logic                busy;
        logic                done;
    } ctrl_s;

    ctrl_s q, d;
    cyc_if cyc ();

    // Address of a command step; the last one picks save or restore
    function automatic logic [12:0] seq_addr(input logic [2:0] step, input nvseq_pkg::op_e op);
        logic [12:0] a;
        a = `SEQ_ADDR_0;
        unique case (step)
            3'h0: a = `SEQ_ADDR_0;                                   // [RULE1] [RULE2]
            3'h1: a = `SEQ_ADDR_1;
            3'h2: a = `SEQ_ADDR_2;
            3'h3: a = `SEQ_ADDR_3;
            3'h4: a = `SEQ_ADDR_4;
            default: a = (op == nvseq_pkg::OP_SAVE) ? `SEQ_ADDR_SAVE  // [RULE1]
                                                    : `SEQ_ADDR_REST; // [RULE2]
        endcase
        return a;
    endfunction

    // Command sequencer; the user port is closed while a sequence runs
    always_comb begin
        d           = q;
        d.req       = 1'b0;
        d.rsp_valid = 1'b0;
        d.done      = 1'b0;
        unique case (q.st)
            nvseq_pkg::M_IDLE: begin
                if (cmd_valid_i && q.ready) begin
                    d.op    = nvseq_pkg::op_e'(cmd_op_i);
                    d.ready = 1'b0;
                    d.busy  = 1'b1;
                    d.req   = 1'b1;
                    if (cmd_op_i == nvseq_pkg::OP_READ || cmd_op_i == nvseq_pkg::OP_WRITE) begin
                        d.we    = (cmd_op_i == nvseq_pkg::OP_WRITE);
                        d.addr  = cmd_word_addr_i;
                        d.wdata = cmd_wdata_i;
                        d.st    = nvseq_pkg::M_ACC;
                    end else begin
                        d.step  = 3'h0;                      // Always start at step 0 [RULE9]
                        d.we    = 1'b0;                      // Steps are reads [RULE8] [RULE4]
                        d.addr  = seq_addr(3'h0, nvseq_pkg::op_e'(cmd_op_i));
                        d.st    = nvseq_pkg::M_SEQ;
                    end
                end
            end
            nvseq_pkg::M_ACC: begin
                if (cyc.ack) begin
                    d.rsp_valid = 1'b1;
                    d.rdata     = cyc.rdata;
                    d.ready     = 1'b1;
                    d.busy      = 1'b0;
                    d.st        = nvseq_pkg::M_IDLE;
                end
            end
            nvseq_pkg::M_SEQ: begin
                // Next step only after the previous one ended; nothing else gets in
                if (cyc.ack) begin
                    if (q.step == `SEQ_LAST_STEP) begin
                        // Data of the last step is high-Z and dropped
                        d.wait_cnt = (q.op == nvseq_pkg::OP_SAVE) ? SAVE_WAIT : REST_WAIT;
                        d.st       = nvseq_pkg::M_NVWAIT;
                    end else begin
                        d.step = q.step + 3'h1;              // Strict order, back to back [RULE3] [RULE5]
                        d.addr = seq_addr(q.step + 3'h1, q.op);
                        d.we   = 1'b0;                       // [RULE4] [RULE8]
                        d.req  = 1'b1;
                    end
                end
            end
            nvseq_pkg::M_NVWAIT: begin
                // Bus stays quiet while the store or refill runs [RULE6] [RULE7]
                if (q.wait_cnt <= 16'h0001) begin
                    d.done  = 1'b1;
                    d.ready = 1'b1;
                    d.busy  = 1'b0;
                    d.step  = 3'h0;
                    d.st    = nvseq_pkg::M_IDLE;             // Back to idle [RULE9]
                end else begin
                    d.wait_cnt = q.wait_cnt - 16'h0001;
                end
            end
        endcase
    end

    // Single state register; clock enable holds everything
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q <= '{st: nvseq_pkg::M_IDLE, op: nvseq_pkg::OP_READ, step: 3'h0,
                   wait_cnt: 16'h0000, req: 1'b0, we: 1'b0, addr: 13'h0000,
                   wdata: 8'h00, ready: 1'b1, rsp_valid: 1'b0, rdata: 8'h00,
                   busy: 1'b0, done: 1'b0};
        end else if (en_i) begin
            q <= d;
        end
    end

    // Request side of the cycle generator
    assign cyc.req       = q.req;
    assign cyc.we        = q.we;
    assign cyc.word_addr = q.addr;
    assign cyc.wdata     = q.wdata;

    cycle_gen u_gen (
        .ref_clk_i   (ref_clk_i),
        .nrst_i      (nrst_i),
        .en_i        (en_i),
        .cyc         (cyc.gen),
        .dq_i        (dq_i),
        .dq_o        (dq_o),
        .dq_oe_n_o   (dq_oe_n_o),
        .word_addr_o (word_addr_o),
        .cs_n_o      (cs_n_o),
        .we_n_o      (we_n_o),
        .oe_n_o      (oe_n_o)
    );

    // User outputs, each a flop of the state struct
    assign cmd_ready_o = q.ready;
    assign rsp_valid_o = q.rsp_valid;
    assign rsp_rdata_o = q.rdata;
    assign busy_o      = q.busy;
    assign done_o      = q.done;
endmodule // nv_host_ctrl

// ### verification/nv_host_ctrl_checker.sv
// Pin-level checks of the save/restore command sequence on nv_host_ctrl.
// Assumes one clock and ports as declared by nv_host_ctrl.
`timescale 1ns/10ps
`include "nvseq_map.svh"
module nv_host_ctrl_checker #(
    parameter logic [15:0] SAVE_WAIT = `SAVE_WAIT_DEF,
    parameter logic [15:0] REST_WAIT = `REST_WAIT_DEF
) (
    input wire logic        ref_clk_i,
    input wire logic        nrst_i,
    input wire logic        en_i,
    input wire logic        cmd_valid_i,
    input wire logic [1:0]  cmd_op_i,
    input wire logic        cmd_ready_o,
    input wire logic        rsp_valid_o,
    input wire logic        busy_o,
    input wire logic        done_o,
    input wire logic        dq_oe_n_o,
    input wire logic [12:0] word_addr_o,
    input wire logic        cs_n_o,
    input wire logic        we_n_o,
    input wire logic        oe_n_o
);
    logic        act_q;
    logic        rest_q;
    logic        csp_q;
    logic [2:0]  k_q;
    logic [15:0] w_q;
    logic [12:0] exp_a;
    wire         fall = csp_q && !cs_n_o;
    wire         acc  = cmd_valid_i && cmd_ready_o && en_i;

    // Address due at the next chip-select fall
    always_comb begin
        case (k_q)
            3'h0: exp_a = `SEQ_ADDR_0;
            3'h1: exp_a = `SEQ_ADDR_1;
            3'h2: exp_a = `SEQ_ADDR_2;
            3'h3: exp_a = `SEQ_ADDR_3;
            3'h4: exp_a = `SEQ_ADDR_4;
            default: exp_a = rest_q ? `SEQ_ADDR_REST : `SEQ_ADDR_SAVE;
        endcase
    end

    // Step and wait counters; cleared by reset so an abort starts over
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            act_q  <= 1'b0;
            rest_q <= 1'b0;
            csp_q  <= 1'b1;
            k_q    <= 3'h0;
            w_q    <= 16'h0000;
        end else begin
            csp_q <= cs_n_o;
            if (acc && cmd_op_i[1]) begin
                act_q  <= 1'b1;
                rest_q <= cmd_op_i[0];
                k_q    <= 3'h0;
                w_q    <= 16'h0000;
            end else if (done_o) begin
                act_q <= 1'b0;
            end
            if (act_q && fall) begin
                k_q <= k_q + 3'h1;
            end
            if (act_q && k_q == 3'h6) begin
                w_q <= w_q + 16'h0001;
            end
        end
    end

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_acc_nv;
        acc && cmd_op_i[1];
    endsequence
    sequence s_first;
        ##[1:8] (!cs_n_o && word_addr_o == `SEQ_ADDR_0);
    endsequence

    property p_start; s_acc_nv |-> s_first; endproperty
    a_start: assert property (p_start) else $error("first step missing");
    property p_order; act_q && fall |-> word_addr_o == exp_a; endproperty
    a_order: assert property (p_order) else $error("step address wrong");
    property p_we; act_q |-> we_n_o; endproperty
    a_we: assert property (p_we) else $error("write strobe in sequence");
    property p_read; act_q && !cs_n_o |-> !oe_n_o && dq_oe_n_o; endproperty
    a_read: assert property (p_read) else $error("step not a read");
    property p_alone; act_q && !done_o |-> !rsp_valid_o && !cmd_ready_o; endproperty
    a_alone: assert property (p_alone) else $error("access inside sequence");
    property p_quiet; act_q && k_q == 3'h6 |-> cs_n_o; endproperty
    a_quiet: assert property (p_quiet) else $error("bus used during nv wait");
    property p_six; done_o |-> act_q && k_q == 3'h6; endproperty
    a_six: assert property (p_six) else $error("done without six steps");
    property p_wait; done_o |-> w_q >= (rest_q ? REST_WAIT : SAVE_WAIT); endproperty
    a_wait: assert property (p_wait) else $error("nv wait cut short");
    property p_idle; done_o |-> cmd_ready_o && !busy_o; endproperty
    a_idle: assert property (p_idle) else $error("not idle after done");
endmodule // nv_host_ctrl_checker

bind nv_host_ctrl nv_host_ctrl_checker #(.SAVE_WAIT(SAVE_WAIT), .REST_WAIT(REST_WAIT)) chk_inst (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .en_i(en_i), .cmd_valid_i(cmd_valid_i),
    .cmd_op_i(cmd_op_i), .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o),
    .busy_o(busy_o), .done_o(done_o), .dq_oe_n_o(dq_oe_n_o), .word_addr_o(word_addr_o),
    .cs_n_o(cs_n_o), .we_n_o(we_n_o), .oe_n_o(oe_n_o));

// ### verification/nv_mem_model.sv
// Behavioural 8K x 8 memory with shadow store and command detector.
// Assumes pins from nv_host_ctrl; no clock, events on chip select.
`timescale 1ns/10ps
`include "nvseq_map.svh"
module nv_mem_model #(
    parameter int NV_NS = 500
) (
    input  wire logic        cs_n_i,
    input  wire logic        we_n_i,
    input  wire logic        oe_n_i,
    input  wire logic [12:0] addr_i,
    input  wire logic [7:0]  dq_i,
    input  wire logic        dq_oe_n_i,
    output logic      [7:0]  dq_o,
    output int               n_save_o,
    output int               n_rest_o,
    output logic             viol_o
);
    localparam logic [12:0] SEQ [5] = '{`SEQ_ADDR_0, `SEQ_ADDR_1, `SEQ_ADDR_2,
                                        `SEQ_ADDR_3, `SEQ_ADDR_4};
    logic [7:0] mem [8192];
    logic [7:0] nv  [8192];
    logic [7:0] last_q = 8'h00;
    logic [2:0] step = 3'h0;
    logic       busy = 1'b0;
    logic       wr = 1'b0;
    initial n_save_o = 0;
    initial n_rest_o = 0;
    initial viol_o = 1'b0;

    // Data only on a selected read; otherwise a flipping pattern, never stale
    assign dq_o = (!cs_n_i && !oe_n_i && we_n_i && !busy) ? mem[addr_i] : ~last_q;

    // Each chip-select fall is one detector step; delay lets strobes settle
    always @(negedge cs_n_i) begin
        #1;
        wr = !we_n_i;
        if (busy) viol_o = 1'b1;
        else if (wr) step = 3'h0;
        else if (step == 3'h5 && (addr_i == `SEQ_ADDR_SAVE || addr_i == `SEQ_ADDR_REST)) begin
            step = 3'h0;
            busy = 1'b1;
            if (addr_i[0]) begin
                nv = mem;
                n_save_o++;
            end else begin
                foreach (mem[i]) mem[i] = 8'h00;
                mem = nv;
                n_rest_o++;
            end
        end
        else if (step < 3'h5 && addr_i == SEQ[step]) step = step + 3'h1;
        else step = {2'h0, addr_i == `SEQ_ADDR_0};
    end

    // Part stays off the bus for a fixed time after a save or restore
    always @(posedge busy) #NV_NS busy = 1'b0;

    // Writes land at the end of the chip-select pulse
    always @(posedge cs_n_i) begin
        if (wr && !dq_oe_n_i && !busy) mem[addr_i] = dq_i;
        last_q = ~last_q;
    end
endmodule // nv_mem_model

// ### verification/tb_nv_save_restore_sequence_detector.sv
// Self-checking bench for nv_host_ctrl against the memory model.
// Assumes 10 MHz clock; short nv waits keep the run small.
`timescale 1ns/10ps
module tb_nv_save_restore_sequence_detector;
    logic        ref_clk_i, nrst_i, en_i, cmd_valid_i, viol;
    logic [1:0]  cmd_op_i;
    logic [12:0] cmd_word_addr_i, word_addr_o;
    logic [7:0]  cmd_wdata_i, rsp_rdata_o, dq_i, dq_o;
    logic        cmd_ready_o, rsp_valid_o, busy_o, done_o, dq_oe_n_o, cs_n_o, we_n_o, oe_n_o;
    int          err_total = 0, n_tests = 0, cyc = 0, n_save, n_rest;

    nv_host_ctrl #(.SAVE_WAIT(16'h0008), .REST_WAIT(16'h0008)) nv_host_ctrl_inst (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .en_i(en_i), .cmd_valid_i(cmd_valid_i),
        .cmd_op_i(cmd_op_i), .cmd_word_addr_i(cmd_word_addr_i), .cmd_wdata_i(cmd_wdata_i),
        .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
        .busy_o(busy_o), .done_o(done_o), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o),
        .word_addr_o(word_addr_o), .cs_n_o(cs_n_o), .we_n_o(we_n_o), .oe_n_o(oe_n_o));
    nv_mem_model nv_mem_model_inst (
        .cs_n_i(cs_n_o), .we_n_i(we_n_o), .oe_n_i(oe_n_o), .addr_i(word_addr_o),
        .dq_i(dq_o), .dq_oe_n_i(dq_oe_n_o), .dq_o(dq_i), .n_save_o(n_save),
        .n_rest_o(n_rest), .viol_o(viol));

    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    // Hang guard: well above the fewer than two hundred cycles the run needs
    always @(negedge ref_clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask

    // One user request, then wait for its completion pulse
    task automatic op(input logic [1:0] o, input logic [12:0] a, input logic [7:0] d);
        int n;
        n = 0;
        // Ready looked at on the falling edge, clear of the edge that moves it
        @(negedge ref_clk_i);
        while (cmd_ready_o !== 1'b1 && n < 50) begin
            @(negedge ref_clk_i);
            n++;
        end
        cmd_valid_i = 1'b1;
        cmd_op_i = o;
        cmd_word_addr_i = a;
        cmd_wdata_i = d;
        @(negedge ref_clk_i);
        cmd_valid_i = 1'b0;
        while (rsp_valid_o !== 1'b1 && done_o !== 1'b1 && n < 200) begin
            @(negedge ref_clk_i);
            n++;
        end
        chk("completion", 1, n < 200);
    endtask

    task automatic t_rw();
        op(2'h1, 13'h1fff, 8'h5a);
        op(2'h1, 13'h0000, 8'hc3);
        op(2'h0, 13'h1fff, 8'h00);
        chk("read 1fff", 8'h5a, rsp_rdata_o);
        op(2'h0, 13'h0000, 8'h00);
        chk("read 0000", 8'hc3, rsp_rdata_o);
    endtask

    task automatic t_nv();
        op(2'h1, 13'h0123, 8'ha5);
        op(2'h2, 13'h0000, 8'h00);
        chk("saves", 1, n_save);
        op(2'h1, 13'h0123, 8'h3c);
        op(2'h3, 13'h0000, 8'h00);
        chk("restores", 1, n_rest);
        op(2'h0, 13'h0123, 8'h00);
        chk("restored byte", 8'ha5, rsp_rdata_o);
    endtask

    // Reset in mid-sequence, then a full save must still be recognised
    task automatic t_abort();
        logic [12:0] a;
        @(negedge ref_clk_i);
        cmd_valid_i = 1'b1;
        cmd_op_i = 2'h2;
        @(negedge ref_clk_i);
        cmd_valid_i = 1'b0;
        repeat (8) @(negedge ref_clk_i);
        // Clock enable low must hold the pending step where it is
        a = word_addr_o;
        en_i = 1'b0;
        repeat (4) @(negedge ref_clk_i);
        chk("addr while disabled", a, word_addr_o);
        en_i = 1'b1;
        @(negedge ref_clk_i);
        chk("busy mid sequence", 1, busy_o);
        nrst_i = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        chk("ready in reset", 1, cmd_ready_o);
        nrst_i = 1'b1;
        op(2'h2, 13'h0000, 8'h00);
        chk("saves after abort", 2, n_save);
        chk("access while nv busy", 0, viol);
    endtask

    initial begin
        nrst_i = 1'b0;
        en_i = 1'b1;
        cmd_valid_i = 1'b0;
        cmd_op_i = 2'h0;
        cmd_word_addr_i = 13'h0000;
        cmd_wdata_i = 8'h00;
        repeat (7) @(negedge ref_clk_i);
        nrst_i = 1'b1;
        t_rw();
        t_nv();
        t_abort();
        tally_and_finish();
    end
endmodule // tb_nv_save_restore_sequence_detector
